// ### skip_ops_pkg.sv
// package: opcodes, flag layout, widths and bus map for the skip/sub/swap/table unit
package skip_ops_pkg;
  localparam int DATA_W = 8;
  localparam int RAM_AW = 6;
  localparam int ROM_AW = 10;
  localparam int ROM_DW = 14;
  localparam int PAGE_W = 8;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_TBLPTR = 8'h0C;
  localparam logic [7:0] OFS_TBLHI  = 8'h10;
  localparam logic [7:0] OFS_PC     = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RAMWIN = 8'h80;
  // flag bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  // reset values
  localparam logic [7:0]        ACC_RST   = 8'h00;
  localparam logic [3:0]        FLAGS_RST = 4'h0;
  localparam logic [ROM_AW-1:0] PC_RST    = 10'h000;
  localparam logic [7:0]        ALL_ONES  = 8'hFF;
  localparam logic [7:0]        ONE       = 8'h01;
  // instruction word layout: op[15:12] bit[10:8] addr[5:0] / imm[7:0]
  localparam int OP_LSB  = 12;
  localparam int BIT_LSB = 8;
  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_DECA_SZ  = 4'h1,
    OP_SETB     = 4'h2,
    OP_SETBIT   = 4'h3,
    OP_INC_SZ   = 4'h4,
    OP_INCA_SZ  = 4'h5,
    OP_BIT_SNZ  = 4'h6,
    OP_SUB_A    = 4'h7,
    OP_SUB_M    = 4'h8,
    OP_SUB_I    = 4'h9,
    OP_SWAP     = 4'hA,
    OP_NIBBLE_EXCHANGE_TO_ACC    = 4'hB,
    OP_SZ       = 4'hC,
    OP_MOVA_SZ  = 4'hD,
    OP_BIT_SZ   = 4'hE,
    OP_TABRD    = 4'hF
  } op_t;
  typedef struct packed {
    logic [RAM_AW-1:0] addr;
    logic [7:0]        data;
    logic              we;
  } ram_wr_t;
endpackage : skip_ops_pkg

// ### skip_ops_unit.sv
// execution unit for skip, set, subtract, swap and table-read operations
// Overview of operation
// [RL1] acc gets mem minus one; skip on zero
// [RL2] decrement-to-acc leaves memory byte untouched
// [RL3] byte set writes all ones, no flags
// [RL4] bit set forces one bit only
// [RL5] increment memory in place, skip on zero
// [RL6] acc gets mem plus one; skip on zero
// [RL7] skip discards prefetch, adds dummy cycle
// [RL8] skip when selected bit is one
// [RL9] acc minus mem into acc, flags updated
// [RL10] same subtraction, result into memory
// [RL11] acc minus immediate, flags updated
// [RL12] swap nibbles of memory in place
// [RL13] swapped nibbles to acc, memory kept
// [RL14] skip when memory byte is zero
// [RL15] copy memory to acc, skip on zero
// [RL16] skip when selected bit is zero
// [RL17] current-page table read to memory and latch
// [RL18] last-page table read likewise
// [RL19] discarded instruction has no side effects
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module skip_ops_unit
  import skip_ops_pkg::*;
#(
  parameter int RAM_DEPTH = 64,
  parameter int ROM_DEPTH = 1024
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // program rom read port
  output logic [skip_ops_pkg::ROM_AW-1:0] rom_addr_o,
  input  wire logic [skip_ops_pkg::ROM_DW-1:0] rom_data_i,
  // status
  output logic             busy_o
);
  import skip_ops_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_DUMMY = 3'b100
  } state_t;

  state_t             state_reg;
  state_t             state_next;
  logic [15:0]        instr_reg;
  logic [7:0]         acc_reg;
  logic [3:0]         flags_reg;
  logic [7:0]         tblptr_reg;
  logic [7:0]         tblhi_reg;
  logic [ROM_AW-1:0]  pc_reg;
  logic               skipped_reg;
  logic [7:0]         ram [RAM_DEPTH];
  logic               ack_reg;
  logic [31:0]        rdata_reg;
  logic               err_reg;

  function automatic logic [8:0] add_c(input logic [7:0] a, input logic [7:0] b);
    add_c = {1'b0, a} + {1'b0, b} + 9'h001;
  endfunction : add_c

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[3:0], v[7:4]};
  endfunction : nib_swap

  // instruction decode
  op_t               op;
  wire [RAM_AW-1:0]  maddr   = instr_reg[RAM_AW-1:0];
  wire [2:0]         bsel    = instr_reg[BIT_LSB+2:BIT_LSB];
  wire [7:0]         imm     = instr_reg[7:0];
  wire               lastpg  = instr_reg[11];
  wire [7:0]         mval    = ram[maddr];
  wire               mbit    = mval[bsel];
  wire [7:0]         dec_v   = mval - ONE;
  wire [7:0]         inc_v   = mval + ONE;
  wire [7:0]         sub_op  = (op == OP_SUB_I) ? imm : mval;
  wire [8:0]         sub_sum = add_c(acc_reg, ~sub_op);
  wire [4:0]         sub_lo  = {1'b0, acc_reg[3:0]} + {1'b0, ~sub_op[3:0]} + 5'h01;
  wire [7:0]         sub_r   = sub_sum[7:0];
  wire               sub_ov  = (acc_reg[7] == ~sub_op[7]) && (sub_r[7] != acc_reg[7]);
  wire               exec    = (state_reg == ST_EXEC);
  assign op = op_t'(instr_reg[15:OP_LSB]);

  // skip condition per operation
  logic skip_c;
  always_comb begin
    case (op)
      OP_DECA_SZ: skip_c = (dec_v == 8'h00);    // [RL1]
      OP_INC_SZ:  skip_c = (inc_v == 8'h00);    // [RL5]
      OP_INCA_SZ: skip_c = (inc_v == 8'h00);    // [RL6]
      OP_BIT_SNZ: skip_c = mbit;                // [RL8]
      OP_SZ:      skip_c = (mval == 8'h00);     // [RL14]
      OP_MOVA_SZ: skip_c = (mval == 8'h00);     // [RL15]
      OP_BIT_SZ:  skip_c = !mbit;               // [RL16]
      default:    skip_c = 1'b0;
    endcase
  end

  // memory write-back selection
  ram_wr_t mw;
  always_comb begin
    mw.addr = maddr;
    mw.we   = exec;
    case (op)
      OP_SETB:   mw.data = ALL_ONES;                           // [RL3]
      OP_SETBIT: mw.data = mval | (ONE << bsel);               // [RL4]
      OP_INC_SZ: mw.data = inc_v;                              // [RL5]
      OP_SUB_M:  mw.data = sub_r;                              // [RL10]
      OP_SWAP:   mw.data = nib_swap(mval);                     // [RL12]
      OP_TABRD:  mw.data = rom_data_i[7:0];                    // [RL17] [RL18]
      default: begin
        mw.data = mval;
        mw.we   = 1'b0;                                        // [RL2] [RL13]
      end
    endcase
  end

  // accumulator result selection
  logic       acc_we;
  logic [7:0] acc_d;
  always_comb begin
    acc_we = exec;
    case (op)
      OP_DECA_SZ: acc_d = dec_v;                  // [RL1]
      OP_INCA_SZ: acc_d = inc_v;                  // [RL6]
      OP_SUB_A:   acc_d = sub_r;                  // [RL9]
      OP_SUB_I:   acc_d = sub_r;                  // [RL11]
      OP_NIBBLE_EXCHANGE_TO_ACC:   acc_d = nib_swap(mval);         // [RL13]
      OP_MOVA_SZ: acc_d = mval;                   // [RL15]
      default: begin
        acc_d  = acc_reg;
        acc_we = 1'b0;
      end
    endcase
  end
  wire flags_we = exec && (op == OP_SUB_A || op == OP_SUB_M || op == OP_SUB_I); // [RL9]

  // table address: page from pc or last page, low bits from the pointer
  wire [ROM_AW-1:0] pg_cur = pc_reg;
  assign rom_addr_o = lastpg ? {{(ROM_AW-PAGE_W){1'b1}}, tblptr_reg}        // [RL18]
                             : {pg_cur[ROM_AW-1:PAGE_W], tblptr_reg};       // [RL17]

  // wishbone decode
  wire bus_req  = cyc_i && stb_i && !ack_reg && !err_reg;
  // window is the upper half of the byte map; only words 0..31 are bus-visible
  wire ram_hit  = adr_i >= OFS_RAMWIN;
  wire [RAM_AW-1:0] bus_ra = RAM_AW'(adr_i[6:2]);
  wire hit = ram_hit || adr_i inside {OFS_INSTR, OFS_ACC, OFS_FLAGS, OFS_TBLPTR,
                                      OFS_TBLHI, OFS_PC, OFS_STATUS};
  // a new instruction is only accepted while idle; the bus acks but drops it when busy
  wire wr_go    = bus_req && hit && we_i && sel_i[0];
  wire start    = wr_go && adr_i == OFS_INSTR && sel_i[1] && state_reg == ST_IDLE;
  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      OFS_INSTR:  rd_mux = {16'h0000, instr_reg};
      OFS_ACC:    rd_mux = {24'h000000, acc_reg};
      OFS_FLAGS:  rd_mux = {28'h0000000, flags_reg};
      OFS_TBLPTR: rd_mux = {24'h000000, tblptr_reg};
      OFS_TBLHI:  rd_mux = {24'h000000, tblhi_reg};
      OFS_PC:     rd_mux = {22'h000000, pc_reg};
      OFS_STATUS: rd_mux = {30'h00000000, skipped_reg, state_reg != ST_IDLE};
      default:    rd_mux = ram_hit ? {24'h000000, ram[bus_ra]} : 32'h00000000;
    endcase
  end

  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = start ? ST_EXEC : ST_IDLE;
      ST_EXEC:  state_next = skip_c ? ST_DUMMY : ST_IDLE;    // [RL7]
      ST_DUMMY: state_next = ST_IDLE;                        // [RL7] [RL19]
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      acc_reg     <= ACC_RST;
      flags_reg   <= FLAGS_RST;
      pc_reg      <= PC_RST;
      instr_reg   <= 16'h0000;
      tblptr_reg  <= 8'h00;
      tblhi_reg   <= 8'h00;
      skipped_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start) begin
        instr_reg <= {dat_i[15:8], dat_i[7:0]};
      end
      if (wr_go && adr_i == OFS_ACC && state_reg == ST_IDLE) begin
        acc_reg <= dat_i[7:0];
      end else if (acc_we) begin
        acc_reg <= acc_d;
      end
      if (wr_go && adr_i == OFS_TBLPTR) begin
        tblptr_reg <= dat_i[7:0];
      end
      if (wr_go && adr_i == OFS_PC && sel_i[1]) begin
        pc_reg <= dat_i[ROM_AW-1:0];
      end else if (exec) begin
        pc_reg <= pc_reg + (skip_c ? ROM_AW'(2) : ROM_AW'(1)); // [RL7] [RL19]
      end
      if (flags_we) begin
        flags_reg[FLG_C]  <= sub_sum[8];                       // [RL9] [RL10] [RL11]
        flags_reg[FLG_AC] <= sub_lo[4];
        flags_reg[FLG_Z]  <= (sub_r == 8'h00);
        flags_reg[FLG_OV] <= sub_ov;
      end
      if (exec && op == OP_TABRD) begin
        tblhi_reg <= {2'b00, rom_data_i[ROM_DW-1:8]};         // [RL17] [RL18]
      end
      if (exec) begin
        skipped_reg <= skip_c;
      end
    end
  end

  // data memory: execution writes win over bus writes in the same cycle
  always_ff @(posedge clk_i) begin
    if (mw.we) begin
      ram[mw.addr] <= mw.data;
    end else if (wr_go && ram_hit) begin
      ram[bus_ra] <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= bus_req && hit;
      err_reg   <= bus_req && !hit;
      rdata_reg <= rd_mux;
    end
  end

  assign ack_o  = ack_reg;
  assign err_o  = err_reg;
  assign dat_o  = rdata_reg;
  assign busy_o = (state_reg != ST_IDLE);

  // results are registered at the end of the execute cycle, so they are checked one edge later
  a_skip_dummy: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
    exec && skip_c |=> state_reg == ST_DUMMY ##1 state_reg == ST_IDLE)
    else $error("skip did not insert one dummy cycle");
  a_noskip_one: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
    exec && !skip_c |=> state_reg == ST_IDLE)
    else $error("non-skip took more than one cycle");
  a_dummy_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RL19]
    state_reg == ST_DUMMY |=> $stable(acc_reg) && $stable(flags_reg) && $stable(pc_reg))
    else $error("dummy cycle changed state");
  a_deca_mem: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1] [RL2]
    exec && op == OP_DECA_SZ |=> ram[$past(maddr)] == $past(mval)
      && acc_reg == $past(mval) - ONE)
    else $error("decrement-to-acc wrong");
  a_deca_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
    exec && op == OP_DECA_SZ |=> (state_reg == ST_DUMMY) == ($past(mval) == ONE))
    else $error("decrement skip decision wrong");
  a_set_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    exec && op == OP_SETB |=> ram[$past(maddr)] == ALL_ONES && $stable(flags_reg))
    else $error("byte set wrong");
  a_set_bit: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    exec && op == OP_SETBIT |=> ram[$past(maddr)] == ($past(mval) | (ONE << $past(bsel))))
    else $error("bit set wrong");
  a_inc_mem: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    exec && op == OP_INC_SZ |=> ram[$past(maddr)] == $past(mval) + ONE)
    else $error("increment in place wrong");
  a_inc_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    exec && op == OP_INC_SZ |=> (state_reg == ST_DUMMY) == ($past(mval) == ALL_ONES))
    else $error("increment skip decision wrong");
  a_inca_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    exec && op == OP_INCA_SZ |=> acc_reg == $past(mval) + ONE
      && ram[$past(maddr)] == $past(mval)
      && (state_reg == ST_DUMMY) == ($past(mval) == ALL_ONES))
    else $error("increment-to-acc wrong");
  a_snz_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    exec && op == OP_BIT_SNZ |=> (state_reg == ST_DUMMY) == $past(mbit))
    else $error("bit nonzero skip decision wrong");
  a_sub_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
    exec && op == OP_SUB_A |=> acc_reg == $past(acc_reg) - $past(mval)
      && flags_reg[FLG_Z] == (acc_reg == 8'h00))
    else $error("subtract result or zero flag wrong");
  a_sub_carry: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
    exec && op == OP_SUB_A |=> flags_reg[FLG_C] == ($past(acc_reg) >= $past(mval)))
    else $error("subtract carry wrong");
  a_subtract_to_memory_mem: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
    exec && op == OP_SUB_M |=> ram[$past(maddr)] == $past(acc_reg) - $past(mval)
      && $stable(acc_reg))
    else $error("subtract to memory wrong");
  a_subi_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    exec && op == OP_SUB_I |=> acc_reg == $past(acc_reg) - $past(imm))
    else $error("subtract immediate wrong");
  a_swap_mem: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
    exec && op == OP_SWAP |=> ram[$past(maddr)] == {$past(mval[3:0]), $past(mval[7:4])})
    else $error("swap in place wrong");
  a_nibble_exchange_to_acc_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
    exec && op == OP_NIBBLE_EXCHANGE_TO_ACC |=> acc_reg == {$past(mval[3:0]), $past(mval[7:4])}
      && $stable(flags_reg))
    else $error("swap to acc wrong");
  a_mem_kept: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2] [RL13] [RL14]
    exec && op inside {OP_DECA_SZ, OP_INCA_SZ, OP_NIBBLE_EXCHANGE_TO_ACC, OP_SZ, OP_MOVA_SZ}
      |=> ram[$past(maddr)] == $past(mval))
    else $error("memory changed by a to-acc operation");
  a_sz_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL14]
    exec && op == OP_SZ && mval == 8'h00 |=> pc_reg == $past(pc_reg) + ROM_AW'(2))
    else $error("zero test skip missing");
  a_mova_acc: assert property (@(posedge clk_i) disable iff (rst_i) // [RL15]
    exec && op == OP_MOVA_SZ |=> acc_reg == $past(mval)
      && (state_reg == ST_DUMMY) == ($past(mval) == 8'h00))
    else $error("move test skip wrong");
  a_bitz_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL16]
    exec && op == OP_BIT_SZ |=> (state_reg == ST_DUMMY) == !$past(mbit))
    else $error("bit zero skip decision wrong");
  a_table_cur: assert property (@(posedge clk_i) disable iff (rst_i) // [RL17]
    exec && op == OP_TABRD && !lastpg
      |-> rom_addr_o[ROM_AW-1:PAGE_W] == pc_reg[ROM_AW-1:PAGE_W] && rom_addr_o[7:0] == tblptr_reg)
    else $error("current page table address wrong");
  a_table_last: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
    exec && op == OP_TABRD && lastpg |-> rom_addr_o[7:0] == tblptr_reg
      && rom_addr_o[ROM_AW-1:PAGE_W] == {(ROM_AW-PAGE_W){1'b1}})
    else $error("last page table address wrong");
  a_table_data: assert property (@(posedge clk_i) disable iff (rst_i) // [RL17] [RL18]
    exec && op == OP_TABRD |=> tblhi_reg == {2'h0, $past(rom_data_i[ROM_DW-1:8])}
      && ram[$past(maddr)] == $past(rom_data_i[7:0]))
    else $error("table word not split into memory and latch");
  a_flags_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1] [RL12] [RL17]
    exec && !(op inside {OP_SUB_A, OP_SUB_M, OP_SUB_I}) |=> $stable(flags_reg))
    else $error("flags changed by a flag-free operation");
  c_skip_taken: cover property (@(posedge clk_i) exec && skip_c);
  c_sub_carry: cover property (@(posedge clk_i) flags_we && sub_sum[8]);
  c_table_last: cover property (@(posedge clk_i) exec && op == OP_TABRD && lastpg);
  c_table_cur: cover property (@(posedge clk_i) exec && op == OP_TABRD && !lastpg);
  c_sub_overflow: cover property (@(posedge clk_i) flags_we && sub_ov);
endmodule : skip_ops_unit

// ### skip_rom_model.sv
// program rom model: asynchronous word lookup derived from the address
`timescale 1ns/1ps
module skip_rom_model
  import skip_ops_pkg::*;
(
  // rom port
  input  wire logic [skip_ops_pkg::ROM_AW-1:0] addr_i,
  output logic      [skip_ops_pkg::ROM_DW-1:0] data_o
);
  // page bits feed the high part, so a wrong page shows in the latch
  assign data_o = {addr_i[9:8] + 2'h1, addr_i[3:0], addr_i[7:0]};
endmodule : skip_rom_model

// ### mcu_skip_sub_swap_table_ops_tb_top.sv
// testbench for the skip, set, subtract, swap and table-read unit
`timescale 1ns/1ps
module mcu_skip_sub_swap_table_ops_tb_top;
  import skip_ops_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [3:0]        sel = 4'h0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       dat_o;
  logic [31:0]       q;
  logic              ack_o;
  logic              err_o;
  logic              busy_o;
  logic              last_err;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data;
  int                errors = 0;
  int                n_tests = 0;
  int                cycles = 0;

  always #12.5 clk_i = ~clk_i;

  skip_ops_unit i_skip_ops_unit (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .rom_addr_o(rom_addr), .rom_data_i(rom_data), .busy_o(busy_o));
  skip_rom_model i_skip_rom_model (.addr_i(rom_addr), .data_o(rom_data));

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // a whole run is well under this; a hang ends in the report
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // no own limit: only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    last_err = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rchk

  function automatic logic [15:0] mk(op_t o, logic [2:0] b, logic [7:0] a);
    return {o, 1'b0, b, a};
  endfunction : mk

  // keepf: flags are read before and after, so any stray flag update is seen
  task automatic run(input logic [15:0] ins, input logic sk, input logic keepf);
    logic [31:0] pc0;
    logic [31:0] f0;
    int          k;
    wb(1'b0, OFS_FLAGS, 32'h0);
    f0 = q;
    wb(1'b0, OFS_PC, 32'h0);
    pc0 = q;
    wb(1'b1, OFS_INSTR, {16'h0, ins});
    k = 0;
    while (busy_o !== 1'b0 && k < 10) begin
      @(posedge clk_i);
      k++;
    end
    chk("busy done", 32'h0, {31'h0, busy_o});
    rchk(OFS_PC, pc0 + (sk ? 32'h2 : 32'h1), "pc step");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("skipped", {31'h0, sk}, {31'h0, q[1]});
    if (keepf)
      rchk(OFS_FLAGS, f0, "flags kept");
  endtask : run

  task automatic t_dec;
    // acc is zero after reset; zero minus zero sets carry, aux carry and zero
    run(mk(OP_SUB_I, 3'h0, 8'h00), 1'b0, 1'b0);
    rchk(OFS_FLAGS, 32'h7, "flags preset");
    wb(1'b1, 8'h8C, 32'h01);
    run(mk(OP_DECA_SZ, 3'h0, 8'h03), 1'b1, 1'b1);
    rchk(OFS_ACC, 32'h00, "dec acc");
    rchk(8'h8C, 32'h01, "dec mem");
    wb(1'b1, 8'h8C, 32'h00);
    run(mk(OP_DECA_SZ, 3'h0, 8'h03), 1'b0, 1'b1);
    rchk(OFS_ACC, 32'hFF, "dec acc wrap");
  endtask : t_dec

  task automatic t_inc;
    wb(1'b1, 8'h90, 32'hFF);
    run(mk(OP_INC_SZ, 3'h0, 8'h04), 1'b1, 1'b1);
    rchk(8'h90, 32'h00, "inc mem");
    wb(1'b1, 8'h90, 32'h7F);
    run(mk(OP_INCA_SZ, 3'h0, 8'h04), 1'b0, 1'b1);
    rchk(OFS_ACC, 32'h80, "inca acc");
    rchk(8'h90, 32'h7F, "inca mem");
  endtask : t_inc

  task automatic t_set;
    wb(1'b1, 8'h94, 32'h00);
    run(mk(OP_SETB, 3'h0, 8'h05), 1'b0, 1'b1);
    rchk(8'h94, 32'hFF, "set byte");
    wb(1'b1, 8'h94, 32'h81);
    run(mk(OP_SETBIT, 3'h5, 8'h05), 1'b0, 1'b1);
    rchk(8'h94, 32'hA1, "set bit");
    wb(1'b1, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, last_err});
  endtask : t_set

  task automatic t_bits;
    wb(1'b1, 8'h98, 32'h20);
    for (int b = 4; b < 6; b++) begin
      run(mk(OP_BIT_SNZ, 3'(b), 8'h06), b == 5, 1'b1);
      run(mk(OP_BIT_SZ, 3'(b), 8'h06), b != 5, 1'b1);
    end
  endtask : t_bits

  task automatic t_sub;
    wb(1'b1, OFS_ACC, 32'h10);
    wb(1'b1, 8'h9C, 32'h01);
    run(mk(OP_SUB_A, 3'h0, 8'h07), 1'b0, 1'b0);
    rchk(OFS_ACC, 32'h0F, "sub acc");
    rchk(OFS_FLAGS, 32'h1, "sub flags");
    wb(1'b1, OFS_ACC, 32'h80);
    run(mk(OP_SUB_M, 3'h0, 8'h07), 1'b0, 1'b0);
    rchk(8'h9C, 32'h7F, "subtract_to_memory mem");
    rchk(OFS_FLAGS, 32'h9, "subtract_to_memory flags");
    wb(1'b1, OFS_ACC, 32'h05);
    run(mk(OP_SUB_I, 3'h0, 8'h05), 1'b0, 1'b0);
    rchk(OFS_ACC, 32'h00, "subi acc");
    rchk(OFS_FLAGS, 32'h7, "subi flags");
  endtask : t_sub

  task automatic t_swap;
    wb(1'b1, 8'hA0, 32'h3C);
    run(mk(OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h08), 1'b0, 1'b1);
    rchk(OFS_ACC, 32'hC3, "nibble_exchange_to_acc acc");
    rchk(8'hA0, 32'h3C, "nibble_exchange_to_acc mem");
    run(mk(OP_SWAP, 3'h0, 8'h08), 1'b0, 1'b1);
    rchk(8'hA0, 32'hC3, "swap mem");
  endtask : t_swap

  task automatic t_zero;
    wb(1'b1, 8'hA4, 32'h00);
    wb(1'b1, OFS_ACC, 32'h55);
    run(mk(OP_SZ, 3'h0, 8'h09), 1'b1, 1'b1);
    run(mk(OP_MOVA_SZ, 3'h0, 8'h09), 1'b1, 1'b1);
    rchk(OFS_ACC, 32'h00, "mova zero");
    wb(1'b1, 8'hA4, 32'h42);
    run(mk(OP_SZ, 3'h0, 8'h09), 1'b0, 1'b1);
    rchk(8'hA4, 32'h42, "sz mem");
    run(mk(OP_MOVA_SZ, 3'h0, 8'h09), 1'b0, 1'b1);
    rchk(OFS_ACC, 32'h42, "mova acc");
  endtask : t_zero

  task automatic t_table;
    wb(1'b1, OFS_TBLPTR, 32'h12);
    wb(1'b1, OFS_PC, 32'h1F0);
    run(mk(OP_TABRD, 3'h0, 8'h0A), 1'b0, 1'b1);
    rchk(8'hA8, 32'h12, "tab cur low");
    rchk(OFS_TBLHI, 32'h22, "tab cur high");
    wb(1'b1, 8'hA8, 32'h00);
    run(mk(OP_TABRD, 3'h0, 8'h0A) | 16'h0800, 1'b0, 1'b1);
    rchk(8'hA8, 32'h12, "tab last low");
    rchk(OFS_TBLHI, 32'h02, "tab last high");
  endtask : t_table

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_dec();
    t_inc();
    t_set();
    t_bits();
    t_sub();
    t_swap();
    t_zero();
    t_table();
    wrap_up();
  end
endmodule : mcu_skip_sub_swap_table_ops_tb_top
